// ==== core/smm_pkg.sv ====
/*
 * Package for the shift, move and multiply execution group: opcode bytes,
 * field positions, special register selects and reset values.
 * Assumes a 16-bit instruction word and a 32-bit datapath.
 */
// Function
// RQ1: variable left shift, zero above 31; the code tests only the low six amount bits, so 64 shifts by 0
// RQ2: constant left shift by nibble
// RQ3: variable right shift, zero above 31; the code tests only the low six amount bits, so 64 shifts by 0
// RQ4: constant right shift by nibble
// RQ5: copy selected special register to destination
// RQ6: write special register from source b
// RQ7: return address not software writable
// RQ8: unconditional register copy
// RQ9: copy only when true flag clear
// RQ10: copy only when true flag set
// RQ11: sign-extended split byte immediate load
// RQ12: register multiply keeps low word
// RQ13: one multiply serves signed and unsigned
// RQ14: multiply by zero-extended nibble
// RQ15: no status flag changed by group
// RQ16: true flag lives in status word
// RQ17: sixteen registers, single-cycle read and write
package smm_pkg;
    localparam int DW = 32;
    localparam int RW = 4;
    localparam int NREG = 16;
    localparam int SHW = 6;

    // ------------------------------------------------------------
    // instruction field positions (lsb of each field)
    // ------------------------------------------------------------
    localparam int OPC_LSB   = 8;
    localparam int MOVI_LSB  = 12;
    localparam int DST_LSB   = 4;
    localparam int SRC_LSB   = 0;
    localparam int IMMHI_LSB = 8;
    localparam int SPRD_LSB  = 0;
    localparam int SPWR_LSB  = 4;
    localparam int RSVRD_LSB = 2;
    localparam int RSVWR_LSB = 6;
    localparam int SPSEL_W   = 2;

    // ------------------------------------------------------------
    // opcode upper bytes, and the upper nibble of the immediate load
    // ------------------------------------------------------------
    localparam logic [7:0] OP_LSL   = 8'h2c;
    localparam logic [7:0] OP_LSLI  = 8'h0c;
    localparam logic [7:0] OP_LSR   = 8'h2d;
    localparam logic [7:0] OP_LSRI  = 8'h0d;
    localparam logic [7:0] OP_RDSP  = 8'h12;
    localparam logic [7:0] OP_WRSP  = 8'h13;
    localparam logic [7:0] OP_COPY  = 8'h24;
    localparam logic [7:0] OP_COPYF = 8'h38;
    localparam logic [7:0] OP_COPYT = 8'h3c;
    localparam logic [7:0] OP_MUL   = 8'h2e;
    localparam logic [7:0] OP_MULI  = 8'h0e;
    localparam logic [3:0] OP_IMM8  = 4'h7;

    // ------------------------------------------------------------
    // shift limit and special register selects
    // ------------------------------------------------------------
    localparam logic [5:0] SH_MAX   = 6'h1f;
    localparam logic [1:0] SP_STATUS = 2'h0;
    localparam logic [1:0] SP_LINK   = 2'h1;
    localparam logic [1:0] SP_INTRET = 2'h2;
    localparam logic [1:0] SP_TIMER  = 2'h3;

    // true flag bit position within the status word (plain default)
    localparam int TRUE_FLAG_BIT = 0;
    localparam logic [DW-1:0] SP_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        SMM_NONE, SMM_LSL, SMM_LSLI, SMM_LSR, SMM_LSRI, SMM_RDSP,
        SMM_WRSP, SMM_COPY, SMM_COPYF, SMM_COPYT, SMM_IMM8,
        SMM_MUL, SMM_MULI
    } smm_op_t;
endpackage

// ==== core/smm_regfile.sv ====
/*
 * Sixteen 32-bit general registers, two asynchronous read ports and one
 * synchronous write port. Assumes a single clock and synchronous reset.
 */
`timescale 1ns/100ps
module smm_regfile (
    input  wire logic                    clk,     // clock
    input  wire logic                    rst_n,   // sync reset, low
    input  wire logic [smm_pkg::RW-1:0]  rdAddrA, // read select a
    input  wire logic [smm_pkg::RW-1:0]  rdAddrB, // read select b
    output logic      [smm_pkg::DW-1:0]  rdDataA, // read data a
    output logic      [smm_pkg::DW-1:0]  rdDataB, // read data b
    input  wire logic                    wrEn,    // write enable
    input  wire logic [smm_pkg::RW-1:0]  wrAddr,  // write select
    input  wire logic [smm_pkg::DW-1:0]  wrData   // write data
);
    logic [smm_pkg::DW-1:0] regs [smm_pkg::NREG];

    // RQ17: sixteen entries, same-cycle read
    assign rdDataA = regs[rdAddrA];
    assign rdDataB = regs[rdAddrB];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < smm_pkg::NREG; i++) begin
                regs[i] <= smm_pkg::SP_RESET;
            end
        end else if (wrEn) begin
            regs[wrAddr] <= wrData;
        end
    end
endmodule

// ==== core/smm_exec.sv ====
/*
 * Decode and single-cycle execution of the shift, move, special register
 * and multiply instruction group. Holds the general registers and the
 * four special registers. Assumes the pipeline presents one instruction
 * per cycle with instrValid; other groups are decoded elsewhere.
 */
`timescale 1ns/100ps
module smm_exec (
    input  wire logic                   clk,        // clock
    input  wire logic                   rst_n,      // sync reset, low
    input  wire logic                   instrValid, // instruction present
    input  wire logic [15:0]            instr,      // instruction word
    input  wire logic                   linkLoad,   // link writes return addr
    input  wire logic [smm_pkg::DW-1:0] linkValue,  // return address value
    output logic                        accepted,   // instruction is ours
    output logic [smm_pkg::DW-1:0]      result,     // last write-back value
    output logic [smm_pkg::DW-1:0]      statusWord, // status word
    output logic [smm_pkg::DW-1:0]      returnAddr, // return address
    output logic [smm_pkg::DW-1:0]      intRetPc,   // interrupt return pc
    output logic [smm_pkg::DW-1:0]      timerReg    // timer register
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic smm_pkg::smm_op_t decodeOp(input logic [15:0] w);
        smm_pkg::smm_op_t op;
        op = smm_pkg::SMM_NONE;
        if (w[smm_pkg::MOVI_LSB +: 4] == smm_pkg::OP_IMM8) begin
            op = smm_pkg::SMM_IMM8;
        end else begin
            unique case (w[smm_pkg::OPC_LSB +: 8])
                smm_pkg::OP_LSL:   op = smm_pkg::SMM_LSL;
                smm_pkg::OP_LSLI:  op = smm_pkg::SMM_LSLI;
                smm_pkg::OP_LSR:   op = smm_pkg::SMM_LSR;
                smm_pkg::OP_LSRI:  op = smm_pkg::SMM_LSRI;
                smm_pkg::OP_RDSP:
                    if (w[smm_pkg::RSVRD_LSB +: 2] == 2'h0)
                        op = smm_pkg::SMM_RDSP;
                smm_pkg::OP_WRSP:
                    if (w[smm_pkg::RSVWR_LSB +: 2] == 2'h0)
                        op = smm_pkg::SMM_WRSP;
                smm_pkg::OP_COPY:  op = smm_pkg::SMM_COPY;
                smm_pkg::OP_COPYF: op = smm_pkg::SMM_COPYF;
                smm_pkg::OP_COPYT: op = smm_pkg::SMM_COPYT;
                smm_pkg::OP_MUL:   op = smm_pkg::SMM_MUL;
                smm_pkg::OP_MULI:  op = smm_pkg::SMM_MULI;
                default:           op = smm_pkg::SMM_NONE;
            endcase
        end
        return op;
    endfunction

    smm_pkg::smm_op_t       op;
    logic [smm_pkg::RW-1:0] rdSel;
    logic [smm_pkg::RW-1:0] srcBSel;
    logic [smm_pkg::DW-1:0] rdVal;
    logic [smm_pkg::DW-1:0] srcBVal;
    logic [smm_pkg::DW-1:0] next_rd;
    logic                   next_wr;
    logic [smm_pkg::DW-1:0] spRead;
    logic [smm_pkg::DW-1:0] nibble;
    logic                   trueFlag;
    logic [1:0]             wrSel;
    logic [1:0]             spSel;
    logic [7:0]             immByte;

    assign op       = instrValid ? decodeOp(instr) : smm_pkg::SMM_NONE;
    assign accepted = (op != smm_pkg::SMM_NONE);
    assign rdSel    = instr[smm_pkg::DST_LSB +: smm_pkg::RW];
    assign srcBSel  = instr[smm_pkg::SRC_LSB +: smm_pkg::RW];
    assign wrSel    = instr[smm_pkg::SPWR_LSB +: smm_pkg::SPSEL_W];
    assign spSel    = instr[smm_pkg::SPRD_LSB +: smm_pkg::SPSEL_W];
    // immediate nibble shares the source b field
    assign nibble   = {{(smm_pkg::DW-smm_pkg::RW){1'b0}}, srcBSel};
    assign immByte  = {instr[smm_pkg::IMMHI_LSB +: 4], srcBSel};
    // RQ16: true flag from status word
    assign trueFlag = statusWord[smm_pkg::TRUE_FLAG_BIT];

    smm_regfile u_regs (
        .clk     (clk),
        .rst_n   (rst_n),
        .rdAddrA (rdSel),
        .rdAddrB (srcBSel),
        .rdDataA (rdVal),
        .rdDataB (srcBVal),
        .wrEn    (next_wr),
        .wrAddr  (rdSel),
        .wrData  (next_rd)
    );

    // RQ5: special register select
    always_comb begin
        unique case (spSel)
            smm_pkg::SP_STATUS: spRead = statusWord;
            smm_pkg::SP_LINK:   spRead = returnAddr;
            smm_pkg::SP_INTRET: spRead = intRetPc;
            smm_pkg::SP_TIMER: spRead = timerReg;
        endcase
    end

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    always_comb begin
        next_rd = rdVal;
        next_wr = 1'b0;
        unique case (op)
            // RQ1: left shift, zero when the low six amount bits exceed 31
            smm_pkg::SMM_LSL: begin
                next_wr = 1'b1;
                next_rd = (srcBVal[smm_pkg::SHW-1:0] > smm_pkg::SH_MAX) ? '0
                        : rdVal << srcBVal[smm_pkg::SHW-2:0];
            end
            // RQ2: left by nibble
            smm_pkg::SMM_LSLI: begin
                next_wr = 1'b1;
                next_rd = rdVal << srcBSel;
            end
            // RQ3: right shift, zero when the low six amount bits exceed 31
            smm_pkg::SMM_LSR: begin
                next_wr = 1'b1;
                next_rd = (srcBVal[smm_pkg::SHW-1:0] > smm_pkg::SH_MAX) ? '0
                        : rdVal >> srcBVal[smm_pkg::SHW-2:0];
            end
            // RQ4: right by nibble
            smm_pkg::SMM_LSRI: begin
                next_wr = 1'b1;
                next_rd = rdVal >> srcBSel;
            end
            // RQ5: special to general
            smm_pkg::SMM_RDSP: begin
                next_wr = 1'b1;
                next_rd = spRead;
            end
            // RQ8: plain copy
            smm_pkg::SMM_COPY: begin
                next_wr = 1'b1;
                next_rd = srcBVal;
            end
            // RQ9: copy when flag clear
            smm_pkg::SMM_COPYF: begin
                next_wr = ~trueFlag;
                next_rd = srcBVal;
            end
            // RQ10: copy when flag set
            smm_pkg::SMM_COPYT: begin
                next_wr = trueFlag;
                next_rd = srcBVal;
            end
            // RQ11: split byte sign extend
            smm_pkg::SMM_IMM8: begin
                next_wr = 1'b1;
                next_rd = {{(smm_pkg::DW-8){immByte[7]}}, immByte};
            end
            // RQ12 RQ13: low word, sign-agnostic
            smm_pkg::SMM_MUL: begin
                next_wr = 1'b1;
                next_rd = smm_pkg::DW'(rdVal * srcBVal);
            end
            // RQ14: zero-extended nibble multiply
            smm_pkg::SMM_MULI: begin
                next_wr = 1'b1;
                next_rd = smm_pkg::DW'(rdVal * nibble);
            end
            default: begin
                next_rd = rdVal;
                next_wr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) result <= smm_pkg::SP_RESET;
        else if (next_wr) result <= next_rd;
    end

    // ------------------------------------------------------------
    // special registers
    // ------------------------------------------------------------
    // RQ6 RQ15: only an explicit write touches the status word
    always_ff @(posedge clk) begin
        if (!rst_n) statusWord <= smm_pkg::SP_RESET;
        else if (op == smm_pkg::SMM_WRSP && wrSel == smm_pkg::SP_STATUS)
            statusWord <= srcBVal;
    end

    // RQ7: return address only from the link path
    always_ff @(posedge clk) begin
        if (!rst_n) returnAddr <= smm_pkg::SP_RESET;
        else if (linkLoad) returnAddr <= linkValue;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) intRetPc <= smm_pkg::SP_RESET;
        else if (op == smm_pkg::SMM_WRSP && wrSel == smm_pkg::SP_INTRET)
            intRetPc <= srcBVal;
    end

    // timer counting lives elsewhere; here it only holds software writes
    always_ff @(posedge clk) begin
        if (!rst_n) timerReg <= smm_pkg::SP_RESET;
        else if (op == smm_pkg::SMM_WRSP && wrSel == smm_pkg::SP_TIMER)
            timerReg <= srcBVal;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_lsl_zero: assert property ( // RQ1
        op == smm_pkg::SMM_LSL && srcBVal[smm_pkg::SHW-1]
        |-> next_wr && next_rd == '0)
        else $error("left shift over 31 not zero");
    chk_lsli_val: assert property ( // RQ2
        op == smm_pkg::SMM_LSLI |-> next_rd == (rdVal << srcBSel))
        else $error("constant left shift wrong");
    chk_lsr_zero: assert property ( // RQ3
        op == smm_pkg::SMM_LSR && srcBVal[smm_pkg::SHW-1]
        |-> next_rd == '0)
        else $error("right shift over 31 not zero");
    chk_lsri_val: assert property ( // RQ4
        op == smm_pkg::SMM_LSRI |-> next_rd == (rdVal >> srcBSel))
        else $error("constant right shift wrong");
    chk_rdsp_link: assert property ( // RQ5
        op == smm_pkg::SMM_RDSP && spSel == smm_pkg::SP_LINK
        |-> next_rd == returnAddr)
        else $error("special read wrong");
    chk_wrsp_intret: assert property ( // RQ6
        op == smm_pkg::SMM_WRSP && wrSel == smm_pkg::SP_INTRET
        |=> intRetPc == $past(srcBVal))
        else $error("special write lost");
    chk_link_locked: assert property ( // RQ7
        !linkLoad |=> $stable(returnAddr))
        else $error("return address changed by software");
    chk_copyf_gate: assert property ( // RQ9
        op == smm_pkg::SMM_COPYF |-> next_wr == !trueFlag)
        else $error("copy-if-false gating wrong");
    chk_copyt_gate: assert property ( // RQ10
        op == smm_pkg::SMM_COPYT |-> next_wr == trueFlag)
        else $error("copy-if-true gating wrong");
    chk_mul_low: assert property ( // RQ12
        op == smm_pkg::SMM_MUL
        |=> result == smm_pkg::DW'($past(rdVal) * $past(srcBVal)))
        else $error("multiply low word wrong");
    chk_status_hold: assert property ( // RQ15
        op != smm_pkg::SMM_WRSP |=> $stable(statusWord))
        else $error("status word changed");

    cov_lsl_big: cover property (op == smm_pkg::SMM_LSL
                                 && srcBVal[smm_pkg::SHW-1]);
    cov_copyt: cover property (op == smm_pkg::SMM_COPYT && trueFlag);
    cov_imm_neg: cover property (op == smm_pkg::SMM_IMM8 && instr[11]);
    cov_wr_link: cover property (op == smm_pkg::SMM_WRSP
                                 && wrSel == smm_pkg::SP_LINK);
endmodule

// ==== tb/test_smm_exec.sv ====
/*
 * Self-checking bench for smm_exec: drives instructions, keeps a model of
 * the general and special registers, and scores every taken instruction.
 * Assumes smm_pkg is compiled first and a single 100 MHz clock.
 */
`timescale 1ns/100ps
module test_smm_exec;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         instrValid = 1'b0;
    logic [15:0]  instr = 16'h0000;
    logic         linkLoad = 1'b0;
    logic [31:0]  linkValue = 32'h0000_0000;
    logic         accepted;
    logic [31:0]  result, statusWord, returnAddr, intRetPc, timerReg;
    logic [31:0]  gr [16];
    logic [31:0]  sp [4];
    logic [31:0]  res;
    logic [31:0]  seed = 32'h0000_5893;
    logic [160:0] expQ [$];
    logic [160:0] e;
    logic         took = 1'b0;
    logic         tookAcc = 1'b0;
    logic [7:0]   ops [12] = '{8'h2c, 8'h0c, 8'h2d, 8'h0d, 8'h12, 8'h13,
                               8'h24, 8'h38, 8'h3c, 8'h2e, 8'h0e, 8'h75};
    logic [7:0]   amt [5] = '{8'h00, 8'h1f, 8'h20, 8'hff, 8'h40};
    int           failCount = 0;
    int           numChecks = 0;

    always #5 clk = ~clk;

    smm_exec dut (
        .clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instr(instr),
        .linkLoad(linkLoad), .linkValue(linkValue), .accepted(accepted),
        .result(result), .statusWord(statusWord), .returnAddr(returnAddr),
        .intRetPc(intRetPc), .timerReg(timerReg)
    );

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task finishTest();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task clearModel();
        for (int k = 0; k < 16; k++) gr[k] = 32'h0;
        for (int k = 0; k < 4; k++) sp[k] = 32'h0;
        res = 32'h0;
    endtask

    // one instruction per edge; model updated in program order
    task exec(input logic [15:0] w, input logic ld);
        logic [31:0] rd, srcB, v, rv;
        logic        wr, acc;
        @(posedge clk);
        rv = rnd();
        instrValid <= 1'b1;
        instr <= w;
        linkLoad <= ld;
        linkValue <= rv;
        if (ld) sp[1] = rv;
        rd = gr[w[7:4]];
        srcB = gr[w[3:0]];
        wr = 1'b1;
        acc = 1'b1;
        v = 32'h0;
        case (w[15:8])
            smm_pkg::OP_LSL:
                v = (srcB[5:0] > 6'h1f) ? 32'h0 : rd << srcB[5:0];
            smm_pkg::OP_LSLI: v = rd << w[3:0];
            smm_pkg::OP_LSR:
                v = (srcB[5:0] > 6'h1f) ? 32'h0 : rd >> srcB[5:0];
            smm_pkg::OP_LSRI: v = rd >> w[3:0];
            smm_pkg::OP_RDSP: begin
                acc = (w[3:2] == 2'h0);
                wr = acc;
                v = sp[w[1:0]];
            end
            smm_pkg::OP_WRSP: begin
                acc = (w[7:6] == 2'h0);
                wr = 1'b0;
                if (acc && w[5:4] != 2'h1) sp[w[5:4]] = srcB;
            end
            smm_pkg::OP_COPY: v = srcB;
            smm_pkg::OP_COPYF: begin
                v = srcB;
                wr = !sp[0][smm_pkg::TRUE_FLAG_BIT];
            end
            smm_pkg::OP_COPYT: begin
                v = srcB;
                wr = sp[0][smm_pkg::TRUE_FLAG_BIT];
            end
            smm_pkg::OP_MUL: v = rd * srcB;
            smm_pkg::OP_MULI: v = rd * {28'h0, w[3:0]};
            default: begin
                acc = (w[15:12] == smm_pkg::OP_IMM8);
                wr = acc;
                v = {{24{w[11]}}, w[11:8], w[3:0]};
            end
        endcase
        if (wr) begin
            gr[w[7:4]] = v;
            res = v;
        end
        expQ.push_back({acc, res, sp[0], sp[1], sp[2], sp[3]});
    endtask

    task idle();
        logic [31:0] noise;
        @(posedge clk);
        noise = rnd();
        instrValid <= 1'b0;
        linkLoad <= 1'b0;
        instr <= noise[15:0];
    endtask

    // ------------------------------------------------------------
    // scoreboard: note what was taken, compare once settled
    // ------------------------------------------------------------
    always @(posedge clk) begin
        took <= rst_n && instrValid;
        tookAcc <= accepted;
    end

    always @(negedge clk) begin
        if (took) begin
            e = expQ.pop_front();
            check("accepted", {31'h0, tookAcc}, {31'h0, e[160]});
            check("result", result, e[159:128]);
            check("statusWord", statusWord, e[127:96]);
            check("returnAddr", returnAddr, e[95:64]);
            check("intRetPc", intRetPc, e[63:32]);
            check("timerReg", timerReg, e[31:0]);
        end
    end

    // about 474 instructions; 20000 cycles leaves ample margin
    initial begin
        #200000;
        failCount++;
        finishTest();
    end

    initial begin
        logic [31:0] t;
        clearModel();
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        exec(16'h0000, 1'b0);
        exec(16'h1204, 1'b0);
        exec(16'h1340, 1'b0);
        exec(16'h7800, 1'b0);
        exec(16'h77ff, 1'b0);
        for (int i = 0; i < 16; i++) begin
            t = rnd();
            exec({4'h7, t[7:4], i[3:0], t[3:0]}, 1'b0);
        end
        foreach (amt[k]) begin
            exec({4'h7, amt[k][7:4], 4'h2, amt[k][3:0]}, 1'b0);
            exec(16'h7f1f, 1'b0);
            exec(16'h2c12, 1'b0);
            exec(16'h7f1f, 1'b0);
            exec(16'h2d12, 1'b0);
        end
        exec(16'h0c1f, 1'b0);
        exec(16'h0d3f, 1'b0);
        exec(16'h0d40, 1'b0);
        exec(16'h2e3e, 1'b0);
        exec(16'h0e3f, 1'b0);
        exec(16'h0e40, 1'b0);
        for (int s = 0; s < 4; s++) begin
            exec({8'h13, 2'b00, s[1:0], 4'h3}, 1'b0);
            exec({8'h12, 4'h4, 2'b00, s[1:0]}, 1'b0);
        end
        exec(16'h0000, 1'b1);
        exec(16'h1241, 1'b0);
        for (int f = 0; f < 2; f++) begin
            exec({8'h70, 4'h5, 3'b000, f[0]}, 1'b0);
            exec(16'h1305, 1'b0);
            exec(16'h3867, 1'b0);
            exec(16'h3c68, 1'b0);
            exec(16'h2469, 1'b0);
        end
        repeat (400) begin
            t = rnd();
            exec({ops[t[19:16] % 12], t[7:0]},
                 t[22:20] == 3'h0 && ops[t[19:16] % 12] != 8'h12);
        end
        idle();
        @(posedge clk);
        rst_n <= 1'b0;
        clearModel();
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        exec(16'h1210, 1'b0);
        exec(16'h1211, 1'b0);
        idle();
        repeat (3) @(posedge clk);
        finishTest();
    end
endmodule
